// File: logic/backdoor_key_match.sv
// Compares four presented backdoor keys against the stored keys.
// Assumes both key sets are stable while the result is sampled.
`timescale 1ns/1ps
module backdoor_key_match (
    // Key sets, word 0 in the low bits
    input  wire logic [63:0] presented,
    input  wire logic [63:0] stored,
    // Result
    output logic             match
);
    always_comb begin
        match = 1'b1;
        for (int i = 0; i < flash_sec_pkg::KEY_WORDS; i++) begin
            if (presented[i*16 +: 16] != stored[i*16 +: 16])
                match = 1'b0;
            if (flash_sec_pkg::key_invalid(presented[i*16 +: 16]) ||
                flash_sec_pkg::key_invalid(stored[i*16 +: 16]))
                match = 1'b0;
        end
    end
endmodule

// File: logic/flash_sec_pkg.sv
// Constants shared by the flash security and reset-initialisation logic.
// Assumes 24-bit flash byte addressing and a 250 MHz core clock.
package flash_sec_pkg;

    // Configuration field locations
    localparam logic [23:0] KEY_BASE_ADDR  = 24'hFFFE00;
    localparam logic [23:0] PROT_WORD_ADDR = 24'hFFFE0C;
    localparam logic [23:0] OPT_WORD_ADDR  = 24'hFFFE0E;
    localparam logic [23:0] SEC_BYTE_ADDR  = 24'hFFFE0F;
    localparam logic [23:0] BLKCFG_ADDR    = 24'hFFFE10;

    // Init read sequence: protection, option/security, block config, keys
    localparam logic [2:0] RD_PROT      = 3'h0;
    localparam logic [2:0] RD_OPT_SEC   = 3'h1;
    localparam logic [2:0] RD_BLKCFG    = 3'h2;
    localparam logic [2:0] RD_KEY_FIRST = 3'h3;
    localparam logic [2:0] RD_LAST      = 3'h6;
    localparam logic [2:0] HOLD_READS   = 3'h3;

    // Security register fields
    localparam int          SEC_LSB       = 0;
    localparam int          BACKDOOR_KEY_ENABLE_LSB     = 6;
    localparam logic [1:0]  SEC_UNSECURE  = 2'h2;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_ENABLED = 2'h2;
    localparam logic [1:0]  MEMORY_CONTROLLER_STATUS_DBF    = 2'h3;

    // Built-in fallbacks: secured, backdoor off, all protected
    localparam logic [7:0]  DEF_SEC    = 8'hFF;
    localparam logic [7:0]  DEF_PROT   = 8'h00;
    localparam logic [7:0]  DEF_OPT    = 8'hFF;
    localparam logic [15:0] DEF_BLKCFG = 16'h0000;

    // Backdoor keys
    localparam int          KEY_WORDS  = 4;
    localparam int          KEY_W      = 16;
    localparam logic [15:0] KEY_ZEROS  = 16'h0000;
    localparam logic [15:0] KEY_ONES   = 16'hFFFF;

    // Verify duration: least time, rounded up
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int VERIFY_TIME_NS = 40;
    localparam int VERIFY_CYC     =
        (VERIFY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    function automatic logic key_invalid(input logic [15:0] k);
        key_invalid = (k == KEY_ZEROS) || (k == KEY_ONES);
    endfunction

endpackage

// File: logic/flash_security_unlock_init.sv
// Flash security state, backdoor unlock and reset initialisation.
// Assumes a flash read port answering one request at a time.
//
// Notes on behaviour
// - Security register loads from configuration byte
// - Reprogrammed security byte acts after reset
// - Four stored 16-bit backdoor key words compared
// - Enabled and matching keys force unsecure state
// - All-zeros and all-ones keys never match
// - Flash reads invalid during key verification
// - Failed verification locks backdoor until reset
// - Verification alters only live security state
// - Unsecured part may rewrite security sector
// - Clean erase-verify in special mode unsecures
// - Reset loads configuration, protection, option, security
// - Init error falls back to secured defaults
// - Double-bit fault at init sets both status bits
// - Complete flag low during init, CPU held for the first three reads
// - Reset aborts any running flash command
`timescale 1ns/1ps
module flash_security_unlock_init (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    // Configuration field reads
    output logic             CFG_RD_REQ,
    output logic [23:0]      CFG_RD_ADDR,
    input  wire logic        CFG_RD_VALID,
    input  wire logic [15:0] CFG_RD_DATA,
    input  wire logic        CFG_RD_DBERR,
    // Backdoor verify command
    input  wire logic        BACKDOOR_START,
    input  wire logic [63:0] BACKDOOR_KEYS,
    // Erase-verify result from debug path
    input  wire logic        ERASE_VERIFY_DONE,
    input  wire logic        ERASE_VERIFY_CLEAN,
    input  wire logic        SPECIAL_SC_MODE,
    // Loaded registers
    output logic [7:0]       SECURITY_REG,
    output logic [7:0]       PFLASH_PROT,
    output logic [7:0]       EEPROM_PROT,
    output logic [7:0]       FLASH_OPTION,
    output logic [15:0]      BLOCK_CONFIG,
    output logic [1:0]       MEMORY_CONTROLLER_STATUS,
    // Status
    output logic             COMMAND_COMPLETE_FLAG,
    output logic             CPU_HOLD,
    output logic             READ_INVALID,
    output logic             SECURED,
    output logic             DEBUG_ALL_EN,
    output logic             SEC_SECTOR_WR_EN,
    output logic             BACKDOOR_LOCKED
);
    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_VERIFY} state_t;

    typedef struct packed {
        state_t      st;
        logic [2:0]  idx;
        logic [3:0]  vcnt;
        logic [7:0]  sec;
        logic [7:0]  pflash_protection_reg;
        logic [7:0]  eeprom_protection_reg;
        logic [7:0]  flash_option_reg;
        logic [15:0] blkcfg;
        logic [63:0] keys;
        logic [63:0] pkeys;
        logic [1:0]  memory_controller_status;
        logic        init_err;
        logic        locked;
        logic        command_complete_flag;
    } core_t;

    core_t s_r;
    core_t s_nxt;
    logic  key_ok;
    logic  bd_go;
    logic  ev_go;
    logic  rd_done;

    backdoor_key_match u_match (
        .presented (s_r.pkeys),
        .stored    (s_r.keys),
        .match     (key_ok)
    );

    function automatic logic [23:0] rd_addr(input logic [2:0] i);
        case (i)
            flash_sec_pkg::RD_PROT:    rd_addr = flash_sec_pkg::PROT_WORD_ADDR;
            flash_sec_pkg::RD_OPT_SEC: rd_addr = flash_sec_pkg::OPT_WORD_ADDR;
            flash_sec_pkg::RD_BLKCFG:  rd_addr = flash_sec_pkg::BLKCFG_ADDR;
            default: rd_addr = flash_sec_pkg::KEY_BASE_ADDR +
                24'({i - flash_sec_pkg::RD_KEY_FIRST, 1'b0});
        endcase
    endfunction

    // Keys only taken when idle, enabled and never failed
    assign bd_go = BACKDOOR_START && (s_r.st == ST_IDLE) && !s_r.locked &&
        (s_r.sec[flash_sec_pkg::BACKDOOR_KEY_ENABLE_LSB +: 2] ==
         flash_sec_pkg::BACKDOOR_KEY_ENABLE_ENABLED);
    assign ev_go = ERASE_VERIFY_DONE && ERASE_VERIFY_CLEAN &&
        SPECIAL_SC_MODE && (s_r.st == ST_IDLE);
    assign rd_done = (s_r.st == ST_INIT) && CFG_RD_VALID;

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            ST_INIT: begin
                if (CFG_RD_VALID) begin
                    if (CFG_RD_DBERR) begin
                        s_nxt.init_err = 1'b1;
                        s_nxt.memory_controller_status   = flash_sec_pkg::MEMORY_CONTROLLER_STATUS_DBF;
                    end
                    case (s_r.idx)
                        flash_sec_pkg::RD_PROT: begin
                            s_nxt.pflash_protection_reg  = CFG_RD_DATA[15:8];
                            s_nxt.eeprom_protection_reg = CFG_RD_DATA[7:0];
                        end
                        flash_sec_pkg::RD_OPT_SEC: begin
                            s_nxt.flash_option_reg = CFG_RD_DATA[15:8];
                            s_nxt.sec  = CFG_RD_DATA[7:0];
                        end
                        flash_sec_pkg::RD_BLKCFG:
                            s_nxt.blkcfg = CFG_RD_DATA;
                        default:
                            s_nxt.keys[16*(s_r.idx -
                                flash_sec_pkg::RD_KEY_FIRST) +: 16] =
                                CFG_RD_DATA;
                    endcase
                    s_nxt.idx = s_r.idx + 3'h1;
                    if (s_r.idx == flash_sec_pkg::RD_LAST) begin
                        s_nxt.st   = ST_IDLE;
                        s_nxt.command_complete_flag = 1'b1;
                        if (s_r.init_err || CFG_RD_DBERR) begin
                            s_nxt.sec    = flash_sec_pkg::DEF_SEC;
                            s_nxt.pflash_protection_reg  = flash_sec_pkg::DEF_PROT;
                            s_nxt.eeprom_protection_reg = flash_sec_pkg::DEF_PROT;
                            s_nxt.flash_option_reg   = flash_sec_pkg::DEF_OPT;
                            s_nxt.blkcfg = flash_sec_pkg::DEF_BLKCFG;
                        end
                    end
                end
            end
            ST_IDLE: begin
                // Security byte is only sampled during init
                if (bd_go) begin
                    s_nxt.st    = ST_VERIFY;
                    s_nxt.command_complete_flag  = 1'b0;
                    s_nxt.pkeys = BACKDOOR_KEYS;
                    s_nxt.vcnt  = 4'(flash_sec_pkg::VERIFY_CYC - 1);
                end else if (ev_go) begin
                    s_nxt.sec[flash_sec_pkg::SEC_LSB +: 2] =
                        flash_sec_pkg::SEC_UNSECURE;
                end
            end
            ST_VERIFY: begin
                if (s_r.vcnt == 4'h0) begin
                    s_nxt.st   = ST_IDLE;
                    s_nxt.command_complete_flag = 1'b1;
                    // Only the live field moves; keys and protection stay
                    if (key_ok)
                        s_nxt.sec[flash_sec_pkg::SEC_LSB +: 2] =
                            flash_sec_pkg::SEC_UNSECURE;
                    else
                        s_nxt.locked = 1'b1;
                end else begin
                    s_nxt.vcnt = s_r.vcnt - 4'h1;
                end
            end
            default: s_nxt.st = ST_INIT;
        endcase
    end

    // Reset drops any command in flight and restarts init
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            s_r          <= '0;
            s_r.st       <= ST_INIT;
            s_r.sec      <= flash_sec_pkg::DEF_SEC;
            s_r.pflash_protection_reg    <= flash_sec_pkg::DEF_PROT;
            s_r.eeprom_protection_reg   <= flash_sec_pkg::DEF_PROT;
            s_r.flash_option_reg     <= flash_sec_pkg::DEF_OPT;
            s_r.blkcfg   <= flash_sec_pkg::DEF_BLKCFG;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign CFG_RD_REQ   = (s_r.st == ST_INIT);
    assign CFG_RD_ADDR  = rd_addr(s_r.idx);
    assign SECURITY_REG = s_r.sec;
    assign PFLASH_PROT  = s_r.pflash_protection_reg;
    assign EEPROM_PROT  = s_r.eeprom_protection_reg;
    assign FLASH_OPTION = s_r.flash_option_reg;
    assign BLOCK_CONFIG = s_r.blkcfg;
    assign MEMORY_CONTROLLER_STATUS       = s_r.memory_controller_status;
    assign COMMAND_COMPLETE_FLAG         = s_r.command_complete_flag;
    assign CPU_HOLD     = (s_r.st == ST_INIT) &&
                          (s_r.idx < flash_sec_pkg::HOLD_READS);
    assign READ_INVALID = (s_r.st == ST_VERIFY);
    assign SECURED      = (s_r.sec[flash_sec_pkg::SEC_LSB +: 2] !=
                           flash_sec_pkg::SEC_UNSECURE);
    assign DEBUG_ALL_EN     = !SECURED;
    assign SEC_SECTOR_WR_EN = !SECURED;
    assign BACKDOOR_LOCKED  = s_r.locked;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    init_done_a: assert property (rd_done && s_r.idx == 3'h6 |=> COMMAND_COMPLETE_FLAG)
        else $error("complete flag not raised at end of init");
    hold_command_complete_flag_a: assert property (CPU_HOLD |-> !COMMAND_COMPLETE_FLAG && !READ_INVALID)
        else $error("complete flag high while CPU held");
    sec_load_a: assert property (rd_done && s_r.idx == 3'h1 &&
        !CFG_RD_DBERR |=> SECURITY_REG == $past(CFG_RD_DATA[7:0]))
        else $error("security register not loaded from config byte");
    err_default_a: assert property (rd_done && s_r.idx == 3'h6 &&
        (s_r.init_err || CFG_RD_DBERR)
        |=> SECURITY_REG == 8'hFF && SECURED)
        else $error("init error did not leave part secured");
    dbfault_stat_a: assert property (rd_done && CFG_RD_DBERR
        |=> MEMORY_CONTROLLER_STATUS == 2'h3)
        else $error("double fault did not set both status bits");
    verify_busy_a: assert property (bd_go |=> READ_INVALID [*8])
        else $error("reads valid during key verification");
    lock_hold_a: assert property (BACKDOOR_LOCKED |=> BACKDOOR_LOCKED)
        else $error("backdoor lock released without reset");
    lock_ignore_a: assert property (BACKDOOR_LOCKED && BACKDOOR_START
        |=> !READ_INVALID)
        else $error("locked backdoor still accepted a command");
    bad_key_a: assert property (bd_go && SECURED &&
        BACKDOOR_KEYS[15:0] == 16'h0000 |-> ##11 SECURED && BACKDOOR_LOCKED)
        else $error("zero key unsecured the part");
    keep_prot_a: assert property (READ_INVALID |=> $stable(PFLASH_PROT) &&
        $stable(EEPROM_PROT) && $stable(SECURITY_REG[7:2]))
        else $error("verification touched protection or stored fields");
    erase_unsec_a: assert property (ev_go |=> DEBUG_ALL_EN)
        else $error("clean erase verify did not unsecure");
    idle_stable_a: assert property (s_r.st == ST_IDLE && !bd_go && !ev_go
        |=> $stable(SECURITY_REG))
        else $error("security changed without a cause");

    init_c: cover property (rd_done && s_r.idx == 3'h6);
    unlock_c: cover property (READ_INVALID && s_r.vcnt == 4'h0 && key_ok);
    lockout_c: cover property (!BACKDOOR_LOCKED ##1 BACKDOOR_LOCKED);
    erase_c: cover property (ev_go && SECURED);
endmodule

// File: tb/cfg_flash_model.sv
// Configuration field model answering the init read port.
// Assumes one read at a time; data lines churn while not valid.
`timescale 1ns/1ps
module cfg_flash_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Read port
    input  wire logic        req,
    input  wire logic [23:0] addr,
    output logic             valid,
    output logic [15:0]      data,
    output logic             dberr,
    // Contents and faults
    input  wire logic        slow,
    input  wire logic        err,
    input  wire logic [7:0]  sec,
    input  wire logic [63:0] keys
);
    logic [1:0] wait_q;
    function automatic logic [15:0] word(input logic [23:0] a);
        if (a[23:3] == flash_sec_pkg::KEY_BASE_ADDR[23:3])
            return keys[a[2:1]*16 +: 16];
        case (a)
            flash_sec_pkg::PROT_WORD_ADDR: return 16'hC3A5;
            flash_sec_pkg::OPT_WORD_ADDR:  return {8'h7E, sec};
            flash_sec_pkg::BLKCFG_ADDR:    return 16'h1234;
            default:                       return 16'h0F0F;
        endcase
    endfunction
    // Slow mode stalls two cycles so the port must hold its request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            valid <= 1'b0;
            dberr <= 1'b0;
            data <= 16'h5A5A;
            wait_q <= 2'h0;
        end else if (req && !valid && wait_q == (slow ? 2'h2 : 2'h0)) begin
            valid <= 1'b1;
            dberr <= err && addr == flash_sec_pkg::OPT_WORD_ADDR;
            data <= word(addr);
            wait_q <= 2'h0;
        end else begin
            valid <= 1'b0;
            dberr <= 1'b0;
            data <= ~data;
            if (req && !valid) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

// File: tb/flash_security_unlock_init_tb_top.sv
// Self-checking bench for the flash security and init block.
// Assumes the config model above; completions checked on COMMAND_COMPLETE_FLAG rise.
`timescale 1ns/1ps
module flash_security_unlock_init_tb_top;
    logic CORE_CLK, RESET, CFG_RD_REQ, CFG_RD_VALID, CFG_RD_DBERR;
    logic BACKDOOR_START, ERASE_VERIFY_DONE, ERASE_VERIFY_CLEAN;
    logic SPECIAL_SC_MODE, COMMAND_COMPLETE_FLAG, CPU_HOLD, READ_INVALID, SECURED;
    logic DEBUG_ALL_EN, SEC_SECTOR_WR_EN, BACKDOOR_LOCKED, slow, inj_err;
    logic [23:0] CFG_RD_ADDR;
    logic [15:0] CFG_RD_DATA, BLOCK_CONFIG;
    logic [63:0] BACKDOOR_KEYS, stored;
    logic [7:0]  SECURITY_REG, PFLASH_PROT, EEPROM_PROT, FLASH_OPTION;
    logic [7:0]  sec_byte;
    logic [1:0]  MEMORY_CONTROLLER_STATUS;
    logic [50:0] exp_q[$];
    logic        command_complete_flag_q;
    int          fail_count, tests_run, cycles, i;
    int          seed = 32'h96a7;
    localparam logic [63:0] KEY_OK = 64'h1111_2222_3333_4444;

    flash_security_unlock_init u_flash_security_unlock_init (.*);
    cfg_flash_model u_cfg_flash_model (.clk(CORE_CLK), .rst(RESET),
        .req(CFG_RD_REQ), .addr(CFG_RD_ADDR), .valid(CFG_RD_VALID),
        .data(CFG_RD_DATA), .dberr(CFG_RD_DBERR), .slow(slow),
        .err(inj_err), .sec(sec_byte), .keys(stored));

    initial begin
        CORE_CLK = 1'b0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end

    function automatic logic [50:0] snap(input logic [7:0] s,
                                         input logic [2:0] ml);
        return {s, 8'hC3, 8'hA5, 8'h7E, 16'h1234, ml};
    endfunction

    task automatic check(input logic [50:0] seen, input logic [50:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Scoreboard: each completion takes the oldest note
    always @(posedge CORE_CLK) begin
        command_complete_flag_q <= COMMAND_COMPLETE_FLAG;
        if (!RESET && COMMAND_COMPLETE_FLAG === 1'b1 && command_complete_flag_q === 1'b0) begin
            if (exp_q.size() == 0) check(51'h0, 51'h1);
            else check({SECURITY_REG, PFLASH_PROT, EEPROM_PROT,
                FLASH_OPTION, BLOCK_CONFIG, MEMORY_CONTROLLER_STATUS, BACKDOOR_LOCKED},
                exp_q.pop_front());
        end
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic reset_run(input logic [7:0] s, input logic e,
                             input logic [50:0] exp);
        @(posedge CORE_CLK);
        sec_byte <= s;
        inj_err <= e;
        RESET <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        #1 check(READ_INVALID, 1'b0);
        @(posedge CORE_CLK);
        RESET <= 1'b0;
        exp_q.push_back(exp);
        @(posedge CORE_CLK);
        #1 check(COMMAND_COMPLETE_FLAG, 1'b0);
        check(CPU_HOLD, 1'b1);
        for (i = 0; i < 100 && COMMAND_COMPLETE_FLAG !== 1'b1; i++) @(posedge CORE_CLK);
        @(posedge CORE_CLK);
        #1 check(CPU_HOLD, 1'b0);
    endtask

    task automatic verify(input logic [63:0] k, input logic taken,
                          input logic [50:0] exp);
        @(posedge CORE_CLK);
        BACKDOOR_START <= 1'b1;
        BACKDOOR_KEYS <= k;
        @(posedge CORE_CLK);
        BACKDOOR_START <= 1'b0;
        if (taken) exp_q.push_back(exp);
        @(posedge CORE_CLK);
        #1 check(READ_INVALID, taken);
        check(COMMAND_COMPLETE_FLAG, !taken);
        repeat (12) @(posedge CORE_CLK);
        #1;
    endtask

    initial begin
        {RESET, BACKDOOR_START, ERASE_VERIFY_DONE} = 3'h4;
        {ERASE_VERIFY_CLEAN, SPECIAL_SC_MODE, slow, inj_err} = 4'h0;
        {fail_count, tests_run, cycles} = '0;
        BACKDOOR_KEYS = 64'h0;
        stored = KEY_OK;
        sec_byte = 8'h80;
        reset_run(8'h80, 1'b0, snap(8'h80, 3'h0));
        check(SECURED, 1'b1);
        check(SEC_SECTOR_WR_EN, 1'b0);
        // Wrong key with odd low bits can never hit 0000 or FFFF
        verify(KEY_OK ^ {48'h0, 16'($random(seed) & 16'hFFFC | 16'h1)}, 1'b1,
               snap(8'h80, 3'h1));
        verify(KEY_OK, 1'b0, 51'h0);
        check(BACKDOOR_LOCKED, 1'b1);
        check(SECURED, 1'b1);
        reset_run(8'h80, 1'b0, snap(8'h80, 3'h0));
        @(posedge CORE_CLK);
        BACKDOOR_START <= 1'b1;
        BACKDOOR_KEYS <= KEY_OK;
        @(posedge CORE_CLK);
        BACKDOOR_START <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        reset_run(8'h80, 1'b0, snap(8'h80, 3'h0));
        verify(KEY_OK, 1'b1, snap(8'h82, 3'h0));
        check(SEC_SECTOR_WR_EN, 1'b1);
        check(PFLASH_PROT, 8'hC3);
        sec_byte <= 8'h81;
        repeat (4) @(posedge CORE_CLK);
        #1 check(SECURITY_REG, 8'h82);
        slow <= 1'b1;
        reset_run(8'h81, 1'b0, snap(8'h81, 3'h0));
        for (int b = 0; b < 2; b++) begin
            stored <= KEY_OK & ~64'h0000_FFFF | (b ? 64'h0000_FFFF : 64'h0);
            reset_run(8'h80, 1'b0, snap(8'h80, 3'h0));
            verify(stored, 1'b1, snap(8'h80, 3'h1));
        end
        stored <= KEY_OK;
        reset_run(8'hC0, 1'b0, snap(8'hC0, 3'h0));
        verify(KEY_OK, 1'b0, 51'h0);
        check(SECURED, 1'b1);
        for (int c = 0; c < 2; c++) begin
            @(posedge CORE_CLK);
            SPECIAL_SC_MODE <= 1'b1;
            ERASE_VERIFY_DONE <= 1'b1;
            ERASE_VERIFY_CLEAN <= c[0];
            @(posedge CORE_CLK);
            ERASE_VERIFY_DONE <= 1'b0;
            @(posedge CORE_CLK);
            #1 check(SECURED, !c[0]);
            check(DEBUG_ALL_EN, c[0]);
        end
        reset_run(8'h80, 1'b1, {8'hFF, 24'h0000FF, 16'h0, 3'h6});
        check(SECURED, 1'b1);
        print_verdict();
    end
endmodule
